// ---- sto_pkg.sv ----
// Purpose: Shared constants for the safe torque off supervisor.
// Assumes: pclk at 20 MHz.
// Notes: Register offsets are byte addresses on APB.
package sto_pkg;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;
  localparam logic [11:0] ADDR_IRQ_EN = 12'h00c;
  localparam logic [11:0] ADDR_IRQ_CLR = 12'h010;
  localparam logic [11:0] ADDR_SPEED = 12'h014;
  localparam logic [11:0] ADDR_PARAM = 12'h018;
  localparam logic [11:0] ADDR_FAULT = 12'h01c;
  // Control register fields.
  localparam int CTRL_RELAY1_LSB = 0;
  localparam int CTRL_RELAY2_LSB = 8;
  localparam int CTRL_START_SRC_LSB = 16;
  localparam int CTRL_CTRL_SRC_LSB = 20;
  localparam int CTRL_AUTO_RESTART = 24;
  localparam int CTRL_PARAM_EDIT = 25;
  localparam logic [7:0] RELAY_SEL_STO = 8'h0d;
  localparam logic [3:0] CTRL_SRC_KEYPAD = 4'h1;
  localparam logic [3:0] START_SRC_TERMINAL = 4'h0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [7:0] TRIP_CODE_STO_FAULT = 8'h1d;
  // Display codes.
  localparam logic [1:0] DISP_STOP = 2'h0;
  localparam logic [1:0] DISP_RUN = 2'h1;
  localparam logic [1:0] DISP_INHIBIT = 2'h2;
  localparam logic [1:0] DISP_TRIP = 2'h3;
  // Interrupt bits.
  localparam int IRQ_STO_ON = 0;
  localparam int IRQ_STO_OFF = 1;
  localparam int IRQ_FAULT = 2;
  localparam int IRQ_W = 3;
  // Timing.
  localparam int CLK_HZ = 20_000_000;
  localparam int TORQUE_OFF_NS = 1_000_000;
  localparam int MONITOR_NS = 20_000_000;
  localparam int DISAGREE_US = 1_000;
  localparam int DISAGREE_CYCLES = DISAGREE_US * (CLK_HZ / 1_000_000);
  localparam int TORQUE_OFF_CYCLES = TORQUE_OFF_NS / (1_000_000_000 / CLK_HZ);
  localparam int MONITOR_CYCLES = MONITOR_NS / (1_000_000_000 / CLK_HZ);
  localparam logic [15:0] SPEED_MAX = 16'hffff;
endpackage

// ---- safe_torque_off_supervisor.sv ----
// Purpose: Safe torque off supervision, relay, display, keypad and APB registers.
// Assumes: Torque-disable channels and keys are synchronous to pclk.
// Notes: Both channels must be high for the drive to be allowed to run.
// Behaviour
// R1: Inputs removed: stop driving at once, coast, enter safe torque off state.
// R2: Inputs energised: standby; start from configured source runs the drive.
// R3: Leave safe torque off only after fault reset and inputs energised again; code needs no reset unless a channel fault is latched.
// R4: Restart after input return may be automatic, depending on configuration.
// R5: Inputs de-energised in normal operation: display shows inhibit.
// R6: Active trip is displayed instead of inhibit.
// R7: Relay one selection 13 opens relay one while safe torque off is active.
// R8: Relay two selection 13 opens relay two while safe torque off is active.
// R9: Internal channel fault raises trip code 29.
// R10: Torque stops within under 1 ms of inputs being removed.
// R11: Monitoring status changes within under 20 ms of removal.
// R12: Channel fault shown and not-healthy output within under 20 ms.
// R13: Safe torque off is always enabled; no setting disables it.
// R14: Start while inputs removed is ignored; inhibit stays displayed.
// R15: Keypad controls the drive only when control source selects keypad.
// R16: Down key lowers speed in real-time mode, parameter in edit mode.
// R17: Both channels needed; disagreement beyond filter interval flags channel fault.
// R18: External controller removes and restores both channels together.
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/10ps
module safe_torque_off_supervisor
  import sto_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sto_ch_a,
  input wire logic sto_ch_b,
  input wire logic start_terminal,
  input wire logic key_start,
  input wire logic key_stop,
  input wire logic key_down,
  input wire logic fault_reset,
  output logic torque_enable,
  output logic relay_one_closed,
  output logic relay_two_closed,
  output logic [1:0] display_code,
  output logic [7:0] trip_code,
  output logic drive_healthy,
  output logic irq
);
  typedef enum logic [1:0] {
    ST_STOPPED = 2'b00,
    ST_RUNNING = 2'b01,
    ST_STO = 2'b10
  } state_e;

  state_e state;
  logic [31:0] ctrl;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_en;
  logic [15:0] speed_ref;
  logic [15:0] param_value;
  logic [31:0] disagree_cnt;
  logic channel_fault;
  logic down_prev;
  logic sto_prev;

  // ---------------------------------------------------------------
  // Input decode
  // ---------------------------------------------------------------
  logic sto_energised;
  logic start_req;
  logic stop_req;
  logic keypad_mode;
  logic wr_en;
  logic down_edge;
  assign sto_energised = sto_ch_a & sto_ch_b; // R17 R13
  assign keypad_mode = ctrl[CTRL_CTRL_SRC_LSB +: 4] == CTRL_SRC_KEYPAD; // R15
  assign start_req = keypad_mode ? key_start : // R15
                     (ctrl[CTRL_START_SRC_LSB +: 4] == START_SRC_TERMINAL) & start_terminal; // R2
  assign stop_req = keypad_mode ? key_stop : ~start_terminal;
  assign wr_en = psel & penable & pwrite;
  assign down_edge = key_down & ~down_prev;

  // ---------------------------------------------------------------
  // Channel disagreement filter
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disagree_cnt <= 32'h0000_0000;
      channel_fault <= 1'b0;
    end else begin
      // The counter saturates, so a long disagreement cannot wrap and hide the fault.
      if (sto_ch_a == sto_ch_b) begin
        disagree_cnt <= 32'h0000_0000;
      end else if (disagree_cnt < DISAGREE_CYCLES) begin
        disagree_cnt <= disagree_cnt + 32'h0000_0001;
      end
      if (sto_ch_a != sto_ch_b && disagree_cnt >= DISAGREE_CYCLES) begin
        channel_fault <= 1'b1; // R17 R9
      end else if (fault_reset) begin
        channel_fault <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Drive state
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_STO;
    end else begin
      case (state)
        ST_STOPPED: begin
          if (!sto_energised || channel_fault) begin
            state <= ST_STO; // R1
          end else if (start_req) begin
            state <= ST_RUNNING; // R2
          end
        end
        ST_RUNNING: begin
          if (!sto_energised || channel_fault) begin
            state <= ST_STO; // R1
          end else if (stop_req) begin
            state <= ST_STOPPED;
          end
        end
        ST_STO: begin
          // Start requests are ignored here unless the inputs are back, no channel fault is latched and auto restart is set.
          if (sto_energised && !channel_fault) begin // R3 R14
            if (ctrl[CTRL_AUTO_RESTART] && start_req) begin
              state <= ST_RUNNING; // R4
            end else begin
              state <= ST_STOPPED;
            end
          end
        end
        default: state <= ST_STO;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      torque_enable <= 1'b0;
      relay_one_closed <= 1'b0;
      relay_two_closed <= 1'b0;
      display_code <= DISP_INHIBIT;
      trip_code <= 8'h00;
      drive_healthy <= 1'b0;
      sto_prev <= 1'b0;
    end else begin
      // Torque drops on the edge after the inputs fall, well under the limit.
      torque_enable <= sto_energised & ~channel_fault & (state == ST_RUNNING); // R10 R1
      relay_one_closed <= (ctrl[CTRL_RELAY1_LSB +: 8] == RELAY_SEL_STO) ? sto_energised : 1'b0; // R7 R11
      relay_two_closed <= (ctrl[CTRL_RELAY2_LSB +: 8] == RELAY_SEL_STO) ? sto_energised : 1'b0; // R8 R11
      if (channel_fault) begin
        display_code <= DISP_TRIP; // R6 R12
      end else if (!sto_energised || state == ST_STO) begin
        display_code <= DISP_INHIBIT; // R5 R14
      end else if (state == ST_RUNNING) begin
        display_code <= DISP_RUN;
      end else begin
        display_code <= DISP_STOP;
      end
      trip_code <= channel_fault ? TRIP_CODE_STO_FAULT : 8'h00; // R9
      drive_healthy <= ~channel_fault; // R12
      sto_prev <= sto_energised;
    end
  end

  // ---------------------------------------------------------------
  // Keypad down key
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      down_prev <= 1'b0;
      speed_ref <= 16'h0000;
      param_value <= 16'h0000;
    end else begin
      down_prev <= key_down;
      if (wr_en && paddr == ADDR_SPEED) begin
        speed_ref <= pwdata[15:0];
      end else if (down_edge && keypad_mode && !ctrl[CTRL_PARAM_EDIT] && speed_ref != 16'h0000) begin
        speed_ref <= speed_ref - 16'h0001; // R16
      end
      if (wr_en && paddr == ADDR_PARAM) begin
        param_value <= pwdata[15:0];
      end else if (down_edge && ctrl[CTRL_PARAM_EDIT] && param_value != 16'h0000) begin
        param_value <= param_value - 16'h0001; // R16
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers and interrupts
  // ---------------------------------------------------------------
  logic [IRQ_W-1:0] irq_events;
  assign irq_events = {channel_fault & ~trip_code[0], ~sto_energised & sto_prev, sto_energised & ~sto_prev};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
      irq_en <= '0;
      irq_stat <= '0;
      irq <= 1'b0;
    end else begin
      if (wr_en && paddr == ADDR_CTRL) begin
        ctrl <= pwdata;
      end
      if (wr_en && paddr == ADDR_IRQ_EN) begin
        irq_en <= pwdata[IRQ_W-1:0];
      end
      // A new event wins over a clear in the same cycle.
      if (wr_en && paddr == ADDR_IRQ_CLR) begin
        irq_stat <= (irq_stat & ~pwdata[IRQ_W-1:0]) | irq_events;
      end else begin
        irq_stat <= irq_stat | irq_events;
      end
      irq <= |(irq_stat & irq_en);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable) begin
        case (paddr)
          ADDR_CTRL: prdata <= ctrl;
          ADDR_STATUS: prdata <= {24'h000000, channel_fault, sto_ch_b, sto_ch_a, 1'b0,
                                  display_code, state};
          ADDR_IRQ_STAT: prdata <= {29'h0, irq_stat};
          ADDR_IRQ_EN: prdata <= {29'h0, irq_en};
          ADDR_IRQ_CLR: prdata <= 32'h0000_0000;
          ADDR_SPEED: prdata <= {16'h0000, speed_ref};
          ADDR_PARAM: prdata <= {16'h0000, param_value};
          ADDR_FAULT: prdata <= {24'h000000, trip_code};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence inputs_removed;
    $fell(sto_ch_a & sto_ch_b);
  endsequence

  AST_STO_ENTER: assert property (!sto_energised |=> state == ST_STO) // R1
    else $error("Safe torque off state not entered.");
  AST_TORQUE_OFF: assert property (inputs_removed |-> ##1 !torque_enable) // R10
    else $error("Torque not removed in time.");
  AST_START_RUN: assert property (state == ST_STOPPED && sto_energised && !channel_fault && start_req // R2
                                  |=> state == ST_RUNNING)
    else $error("Start did not run the drive.");
  AST_NO_LEAVE: assert property (state == ST_STO && (!sto_energised || channel_fault) |=> state == ST_STO) // R3
    else $error("Left safe torque off too early.");
  AST_INHIBIT: assert property (!sto_energised && !channel_fault |=> display_code == DISP_INHIBIT) // R5
    else $error("Inhibit not displayed.");
  AST_TRIP_PRIO: assert property (channel_fault |=> display_code == DISP_TRIP) // R6
    else $error("Trip lost display priority.");
  AST_RELAY1: assert property (ctrl[7:0] == RELAY_SEL_STO && !sto_energised |=> !relay_one_closed) // R7
    else $error("Relay one not open.");
  AST_RELAY2: assert property (ctrl[15:8] == RELAY_SEL_STO && !sto_energised |=> !relay_two_closed) // R8
    else $error("Relay two not open.");
  AST_CODE: assert property (channel_fault |=> trip_code == TRIP_CODE_STO_FAULT && !drive_healthy) // R9
    else $error("Channel fault code wrong.");
  AST_NO_START: assert property (!sto_energised |-> ##1 !torque_enable ##1 !torque_enable) // R14
    else $error("Start accepted while inhibited.");

  // ---------------------------------------------------------------
  // Multi-step checks
  // ---------------------------------------------------------------
  // A channel pair that has disagreed past the filter length.
  sequence fault_sensed;
    (sto_ch_a != sto_ch_b) && (disagree_cnt >= DISAGREE_CYCLES);
  endsequence

  // The display, healthy output and trip code once the channel fault is latched.
  sequence fault_shown;
    display_code == DISP_TRIP && !drive_healthy && trip_code == TRIP_CODE_STO_FAULT;
  endsequence

  // Both channels are back and no fault is latched.
  sequence inputs_returned;
    sto_energised && !channel_fault;
  endsequence

  // A new press of the down key.
  sequence down_pressed;
    key_down && !down_prev;
  endsequence

  AST_FAULT_SHOWN: assert property (fault_sensed |=> channel_fault ##1 fault_shown) // R12
    else $error("Channel fault not shown in time.");
  AST_FILTER_HOLD: assert property ((sto_ch_a != sto_ch_b) && disagree_cnt < DISAGREE_CYCLES // R17
    && !channel_fault |=> !channel_fault)
    else $error("Channel fault raised before the filter ran out.");
  AST_FAULT_STICKY: assert property (channel_fault && !fault_reset |=> channel_fault) // R9
    else $error("Channel fault cleared without a reset.");
  AST_AGREE_NO_FAULT: assert property (sto_ch_a == sto_ch_b && !channel_fault |=> !channel_fault) // R17
    else $error("Channel fault raised while channels agree.");
  AST_BOTH_NEEDED: assert property (torque_enable |-> $past(sto_ch_a) && $past(sto_ch_b)) // R17
    else $error("Torque allowed with a channel removed.");
  AST_AUTO_RESTART: assert property (state == ST_STO ##0 inputs_returned // R4
    ##0 (ctrl[CTRL_AUTO_RESTART] && start_req) |=> state == ST_RUNNING)
    else $error("Automatic restart did not run the drive.");
  AST_LEAVE_STOPPED: assert property (state == ST_STO ##0 inputs_returned // R3
    ##0 !ctrl[CTRL_AUTO_RESTART] |=> state == ST_STOPPED)
    else $error("Drive left safe torque off in the wrong state.");
  AST_RUN_STOP: assert property (state == ST_RUNNING ##0 inputs_returned // R2
    ##0 stop_req |=> state == ST_STOPPED)
    else $error("Stop request ignored.");
  AST_START_IGNORED: assert property (!sto_energised && !channel_fault && start_req // R14
    |=> state == ST_STO && display_code == DISP_INHIBIT)
    else $error("Start acted on while inhibited.");
  AST_ALWAYS_ON: assert property (!sto_energised // R13
    |=> !torque_enable && !relay_one_closed && !relay_two_closed)
    else $error("Safe torque off overridden by a setting.");
  AST_MONITOR: assert property (inputs_removed ##0 $past(presetn) |=> irq_stat[IRQ_STO_OFF]) // R11
    else $error("Removal not recorded in status.");
  AST_IRQ_LEVEL: assert property (|(irq_stat & irq_en) |=> irq) // R11
    else $error("Interrupt output does not follow enabled status.");
  AST_SPEED_GATE: assert property (!keypad_mode && !(wr_en && paddr == ADDR_SPEED) // R15
    |=> $stable(speed_ref))
    else $error("Keypad changed speed outside keypad mode.");
  AST_DOWN_SPEED: assert property (down_pressed // R16
    ##0 (keypad_mode && !ctrl[CTRL_PARAM_EDIT] && speed_ref != 16'h0000 && !(wr_en && paddr == ADDR_SPEED))
    |=> speed_ref == $past(speed_ref) - 16'h0001)
    else $error("Down key did not lower the speed.");
  AST_DOWN_PARAM: assert property (down_pressed // R16
    ##0 (ctrl[CTRL_PARAM_EDIT] && param_value != 16'h0000 && !(wr_en && paddr == ADDR_PARAM))
    |=> param_value == $past(param_value) - 16'h0001)
    else $error("Down key did not lower the parameter.");
endmodule

// ---- sto_relay_model.sv ----
// Purpose: Behavioural external safety relay that feeds both torque-disable channels.
// Assumes: Commands from the bench change just after a rising pclk edge.
// Notes: one_only drops channel b alone, so that only a commanded fault splits the channels.
`timescale 1ns/10ps
module sto_relay_model (
  input wire logic pclk,
  input wire logic energise,
  input wire logic one_only,
  output logic ch_a,
  output logic ch_b
);
  // ----------------------------------------
  // Channel drive
  // ----------------------------------------
  always_ff @(posedge pclk) begin
    ch_a <= energise;
    ch_b <= energise & ~one_only;
  end
endmodule

// ---- safe_torque_off_supervisor_tb_top.sv ----
// Purpose: Self-checking bench for the safe torque off supervisor.
// Assumes: APB slave answers in the access cycle; outputs follow inputs within a few edges.
// Notes: The disagreement filter is a package constant, so the fault test runs its full length.
`timescale 1ns/10ps
module safe_torque_off_supervisor_tb_top;
  import sto_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic sto_ch_a, sto_ch_b, energise, one_only, start_terminal, key_start, key_stop, key_down, fault_reset;
  logic torque_enable, relay_one_closed, relay_two_closed, drive_healthy, e;
  logic [1:0] display_code;
  logic [7:0] trip_code;
  int n_mismatch = 0;
  int checks = 0;
  // ----------------------------------------
  // Instances
  // ----------------------------------------
  safe_torque_off_supervisor dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sto_ch_a(sto_ch_a), .sto_ch_b(sto_ch_b), .start_terminal(start_terminal), .key_start(key_start),
    .key_stop(key_stop), .key_down(key_down), .fault_reset(fault_reset), .torque_enable(torque_enable),
    .relay_one_closed(relay_one_closed), .relay_two_closed(relay_two_closed), .display_code(display_code),
    .trip_code(trip_code), .drive_healthy(drive_healthy), .irq(irq));
  sto_relay_model relay (.pclk(pclk), .energise(energise), .one_only(one_only), .ch_a(sto_ch_a), .ch_b(sto_ch_b));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk(torque_enable, 1'b0);
    chk(display_code, DISP_INHIBIT);
    chk({relay_one_closed, relay_two_closed, irq}, 3'b000);
    $display("test reset done");
  endtask
  task automatic t_run_stop();
    apb(1'b1, ADDR_CTRL, {16'h0000, RELAY_SEL_STO, RELAY_SEL_STO});
    apb(1'b1, ADDR_IRQ_EN, 32'h0000_0007);
    energise <= 1'b1;
    wait_clk(6);
    chk({torque_enable, display_code}, {1'b0, DISP_STOP});
    chk({relay_one_closed, relay_two_closed}, 2'b11);
    apb(1'b1, ADDR_IRQ_CLR, 32'h0000_0007);
    wait_clk(2);
    chk(irq, 1'b0);
    start_terminal <= 1'b1;
    wait_clk(6);
    chk({torque_enable, display_code}, {1'b1, DISP_RUN});
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(r[7:2], {4'b0110, DISP_RUN});
    energise <= 1'b0;
    wait_clk(4);
    chk(torque_enable, 1'b0);
    chk({relay_one_closed, relay_two_closed, display_code}, {2'b00, DISP_INHIBIT});
    chk(irq, 1'b1);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(r[IRQ_STO_OFF], 1'b1);
    apb(1'b1, ADDR_IRQ_CLR, 32'h0000_0007);
    wait_clk(2);
    chk(irq, 1'b0);
    $display("test run_stop done");
  endtask
  task automatic t_ignore_start();
    start_terminal <= 1'b0;
    wait_clk(2);
    start_terminal <= 1'b1;
    wait_clk(6);
    chk({torque_enable, display_code}, {1'b0, DISP_INHIBIT});
    apb(1'b0, 12'h800, 32'h0);
    chk(e, 1'b1);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(r, 32'h0000_0d0d);
    start_terminal <= 1'b0;
    energise <= 1'b1;
    wait_clk(6);
    chk({torque_enable, display_code}, {1'b0, DISP_STOP});
    $display("test ignore_start done");
  endtask
  task automatic t_fault();
    one_only <= 1'b1;
    wait_clk(DISAGREE_CYCLES + 100);
    chk(trip_code, TRIP_CODE_STO_FAULT);
    chk({display_code, drive_healthy, torque_enable}, {DISP_TRIP, 2'b00});
    apb(1'b0, ADDR_FAULT, 32'h0);
    chk(r, {24'h000000, TRIP_CODE_STO_FAULT});
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(r[IRQ_FAULT], 1'b1);
    one_only <= 1'b0;
    fault_reset <= 1'b1;
    wait_clk(3);
    fault_reset <= 1'b0;
    wait_clk(6);
    chk({trip_code, display_code}, {8'h00, DISP_STOP});
    $display("test fault done");
  endtask
  task automatic t_keypad();
    apb(1'b1, ADDR_SPEED, 32'h0000_0100);
    key_down <= 1'b1;
    key_start <= 1'b1;
    wait_clk(4);
    chk(torque_enable, 1'b0);
    key_down <= 1'b0;
    key_start <= 1'b0;
    apb(1'b0, ADDR_SPEED, 32'h0);
    chk(r[15:0], 16'h0100);
    apb(1'b1, ADDR_CTRL, 32'h0010_0000);
    key_down <= 1'b1;
    wait_clk(3);
    key_down <= 1'b0;
    apb(1'b0, ADDR_SPEED, 32'h0);
    chk(r[15:0], 16'h00ff);
    key_start <= 1'b1;
    wait_clk(2);
    key_start <= 1'b0;
    wait_clk(2);
    chk({torque_enable, display_code}, {1'b1, DISP_RUN});
    key_stop <= 1'b1;
    wait_clk(2);
    key_stop <= 1'b0;
    wait_clk(2);
    chk({torque_enable, display_code}, {1'b0, DISP_STOP});
    apb(1'b1, ADDR_PARAM, 32'h0000_0010);
    apb(1'b1, ADDR_CTRL, 32'h0210_0000);
    key_down <= 1'b1;
    wait_clk(3);
    key_down <= 1'b0;
    apb(1'b0, ADDR_PARAM, 32'h0);
    chk(r[15:0], 16'h000f);
    apb(1'b0, ADDR_SPEED, 32'h0);
    chk(r[15:0], 16'h00ff);
    apb(1'b1, ADDR_CTRL, 32'hff00_0d0d);
    start_terminal <= 1'b1;
    wait_clk(4);
    chk(torque_enable, 1'b1);
    energise <= 1'b0;
    wait_clk(3);
    chk({torque_enable, display_code}, {1'b0, DISP_INHIBIT});
    energise <= 1'b1;
    wait_clk(6);
    chk({torque_enable, display_code}, {1'b1, DISP_RUN});
    start_terminal <= 1'b0;
    $display("test keypad done");
  endtask
  // ----------------------------------------
  // Clock, reset, sequence and watchdog
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    energise = 1'b0;
    one_only = 1'b0;
    start_terminal = 1'b0;
    key_start = 1'b0;
    key_stop = 1'b0;
    key_down = 1'b0;
    fault_reset = 1'b0;
    wait_clk(20);
    presetn <= 1'b1;
    wait_clk(2);
    t_reset();
    t_run_stop();
    t_ignore_start();
    t_fault();
    t_keypad();
    give_verdict();
  end
  initial begin
    wait_clk(DISAGREE_CYCLES + 20000);
    $display("[FAIL] %0t watchdog expired", $time);
    n_mismatch++;
    give_verdict();
  end
endmodule
